// >>> opstat_map.svh
/*
 Constants for the operation status encoder: status codes and instruction
 word fields.
 Assumes inclusion by bare name from the package only.
*/
`ifndef OPSTAT_MAP_SVH
`define OPSTAT_MAP_SVH

// ==========================================================
// Status codes
`define OPS_DEFAULT 5'h00
`define OPS_DATA_ADDR 5'h01
`define OPS_INT_ACK 5'h02
`define OPS_RET_FIRST 5'h04
`define OPS_RET_SECOND 5'h07
`define OPS_ST_IMG 5'h08
`define OPS_LD_IMG 5'h0A
`define OPS_ST_COP 5'h0C
`define OPS_LD_COP 5'h0E
`define OPS_EXT_BASE 5'h10
`define OPS_RESERVED 5'h1F

// ==========================================================
// Instruction word fields
`define SEQ_OP_HI 31
`define SEQ_OP_LO 24
`define IMG_OP_HI 23
`define IMG_OP_LO 0
`define SEQ_RET_FIRST 8'hF0
`define SEQ_RET_SECOND 8'hF1
`define SEQ_XFER_CLASS 8'h00
`define XFER_KIND_HI 23
`define XFER_KIND_LO 21
`define XFER_EXT_BIT 15
`define XFER_EXT_HI 14
`define XFER_EXT_LO 11
`define XFER_ST_IMG 3'h1
`define XFER_LD_IMG 3'h2
`define XFER_ST_COP 3'h5
`define XFER_LD_COP 3'h6
`define IMG_AGEN_HI 23
`define IMG_AGEN_LO 20
`define IMG_AGEN_CODE 4'hA
`define IMG_ALIGN_CODE 4'hB
`define EXT_REG_MAX 4'hE

`endif

// >>> opstat_pkg.sv
/*
 Types shared by both ends of the operation status link.
 Assumes opstat_map.svh is on the include path.
*/
package opstat_pkg;
`include "opstat_map.svh"
   typedef logic [4:0] opcode_t;
   typedef logic [31:0] word_t;
endpackage

// >>> opstat_if.sv
/*
 Link between the code sequencer encoder and the external decode logic.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface opstat_if;
   logic [4:0] operation_status_code;
   logic neutralize_n;
   logic [31:0] data_address_bus;
   logic data_address_drive;
   logic master_int_enable;
   logic hold_request;
   modport encoder (output operation_status_code, output neutralize_n,
      output data_address_bus, output data_address_drive,
      output master_int_enable, input hold_request);
   modport decoder (input operation_status_code, input neutralize_n,
      input data_address_bus, input data_address_drive,
      input master_int_enable, output hold_request);
endinterface

// >>> opstat_decoder.sv
/*
 External decode logic: turns status codes into a data address register
 clock, load and store strobes and an external register select.
 Assumes the encoder end on the same clock.
*/
`timescale 1ns/100ps
module opstat_decoder
   import opstat_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // Link.
   opstat_if.decoder link,
   // User side.
   input wire logic i_hold,
   output logic [31:0] o_data_address,
   output logic o_load,
   output logic o_store,
   output logic o_ext_sel,
   output logic [3:0] o_ext_num
);
   typedef struct packed {
      logic [31:0] addr;
      logic load;
      logic store;
      logic ext_sel;
      logic [3:0] ext_num;
      logic hold;
   } dec_s;
   dec_s st_r;
   dec_s st_nxt;

   // ==========================================================
   // Decode; the address register loads only on flagged codes.
   always_comb begin
      logic [4:0] c;
      c = link.operation_status_code;
      st_nxt = st_r;
      st_nxt.hold = i_hold;
      if (c == `OPS_DATA_ADDR || c == `OPS_RET_SECOND ||
          (c[4:3] == 2'b01 && c[0])) begin
         st_nxt.addr = link.data_address_bus; // RULE_14
      end
      st_nxt.load = c[4:3] == 2'b01 && c[1]; // RULE_17
      st_nxt.store = c[4:3] == 2'b01 && !c[1];
      // Register transfers keep the address bus for themselves.
      st_nxt.ext_sel = c[4] && c != `OPS_RESERVED; // RULE_18 RULE_16
      st_nxt.ext_num = c[3:0];
   end

   // The code address latch itself lives outside this block.
   // RULE_19
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.hold_request = st_r.hold;
   assign o_data_address = st_r.addr;
   assign o_load = st_r.load;
   assign o_store = st_r.store;
   assign o_ext_sel = st_r.ext_sel;
   assign o_ext_num = st_r.ext_num;
endmodule

// >>> opstat_encoder.sv
/*
 Operation status encoder of the code sequencer: one code per cycle
 from the latched instruction word and system state.
 Assumes the decoder end on the same clock; reset is asynchronous.
*/
`timescale 1ns/100ps
// Summary of operation
// RULE_01: Examine whole 32-bit word each cycle.
// RULE_02: Default all-zero code otherwise.
// RULE_03: Prior-cycle hold forces default code.
// RULE_04: Address generation gives code 00001.
// RULE_05: Interrupt acknowledge and reset give 00010.
// RULE_06: Acknowledge cycle neutralizes its instruction.
// RULE_07: First return instruction gives 00100.
// RULE_08: Second return gives 00111, drives address; the encoder drives it only when the image half generates an address.
// RULE_09: Restore word: return high, assert low.
// RULE_10: Image store 01000, with address 01001.
// RULE_11: Image load 01010, with address 01011.
// RULE_12: Coprocessor store 0110x, load 0111x.
// RULE_13: External register: 1 plus number.
// RULE_14: Partner clocks address on flagged codes.
// RULE_15: Byte align may emit load code.
// RULE_16: Prefer external registers over memory mapping.
// RULE_17: Memory drives data during loads.
// RULE_18: Register select reserves address bus.
// RULE_19: Partner latches code address transparently.
// RULE_20: Interrupt enable low inside handler.
// RULE_21: Odd code when address generated.
// RULE_22: Branch shadow neutralizes data transfers.
// RULE_23: Code from latched word, held whole cycle.
module opstat_encoder
   import opstat_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // Link.
   opstat_if.encoder link,
   // Sequencer side.
   input wire logic [31:0] i_instr,
   input wire logic i_branch_shadow,
   input wire logic i_int_take,
   input wire logic [31:0] i_adr_reg,
   input wire logic [31:0] i_gen_addr,
   output logic o_shadow_clear
);
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_ACK = 4'h2,
      ST_HANDLER = 4'h4,
      ST_RETURN = 4'h8
   } int_e;

   typedef struct packed {
      int_e phase;
      logic [4:0] code;
      logic neutralize_n_n;
      logic [31:0] ad;
      logic ad_drv;
      logic mie;
      logic shadow_clr;
      logic in_reset;
   } enc_s;
   enc_s st_r;
   enc_s st_nxt;

   // Odd member when the image half generates an address.
   function automatic logic [4:0] pair_code(input logic [4:0] base,
                                            input logic agen);
      pair_code = {base[4:1], agen}; // RULE_21
   endfunction

   // ==========================================================
   // Code selection from the word latched at this edge.
   //
   // The selection is one priority chain, so exactly one code wins in
   // every cycle and the external decoder never sees two at once.
   //
   // Order of the chain, highest first:
   //    1. The cycle right after reset, which repeats the reset code.
   //    2. A hold seen at the end of the previous cycle, which forces
   //       the default code whatever the word holds.
   //    3. The acknowledge cycle of an interrupt.
   //    4. The first and then the second return instruction.
   //    5. An external register transfer.
   //    6. Image and coprocessor stores and loads.
   //    7. A bare address generation in the image half.
   //
   // The hold is taken from the decoder's registered copy, so it acts
   // one cycle after the user raised it; this matches the rule that a
   // hold at the end of one cycle silences the next.
   //
   // Transfers in the branch shadow are dropped here rather than in the
   // decoder, because only this end knows the shadow bit. The image half
   // is still examined in a shadow cycle, since its own address work and
   // its byte align go on regardless of the sequencer op.
   //
   // The byte align reports a load unless a code higher in the chain wins.
   // A memory-mapped peripheral would take that as a real read, which is
   // why register transfers are the recommended way to reach outside logic.
   //
   // Register number fifteen is never produced; such a word falls
   // through to the load and store decode like any other transfer.
   //
   // The address drive flag is raised on every code that tells the
   // decoder to clock its address register, except a second return whose
   // image half generates no address; that one leaves the bus stale.
   //
   // Limitation: the interrupt phase only leaves the handler on the
   // second return op; a handler that never returns keeps the enable low.
   always_comb begin
      logic [7:0] seq_op;
      logic [2:0] kind;
      logic agen;
      logic align;
      logic xfer;
      seq_op = i_instr[`SEQ_OP_HI:`SEQ_OP_LO]; // RULE_01
      kind = i_instr[`XFER_KIND_HI:`XFER_KIND_LO];
      agen = i_instr[`IMG_AGEN_HI:`IMG_AGEN_LO] == `IMG_AGEN_CODE;
      align = i_instr[`IMG_AGEN_HI:`IMG_AGEN_LO] == `IMG_ALIGN_CODE;
      xfer = seq_op == `SEQ_XFER_CLASS && !i_branch_shadow; // RULE_22
      st_nxt = st_r;
      st_nxt.in_reset = 1'b0;
      st_nxt.code = `OPS_DEFAULT; // RULE_02
      st_nxt.neutralize_n_n = !i_branch_shadow;
      st_nxt.ad_drv = 1'b0;
      st_nxt.ad = st_r.ad;
      st_nxt.shadow_clr = i_branch_shadow;
      case (st_r.phase)
         ST_RUN: begin
            if (i_int_take) begin
               st_nxt.phase = ST_ACK;
            end
         end
         ST_ACK: begin
            st_nxt.phase = ST_HANDLER;
         end
         ST_HANDLER: begin
            if (seq_op == `SEQ_RET_SECOND) begin
               st_nxt.phase = ST_RETURN;
            end
         end
         ST_RETURN: begin
            st_nxt.phase = ST_RUN;
         end
         default: begin
            st_nxt.phase = ST_RUN;
         end
      endcase
      st_nxt.mie = st_nxt.phase == ST_RUN || st_nxt.phase == ST_RETURN; // RULE_20
      if (st_r.in_reset) begin
         st_nxt.code = `OPS_INT_ACK; // RULE_05
      end else if (link.hold_request) begin
         st_nxt.code = `OPS_DEFAULT; // RULE_03
      end else if (st_nxt.phase == ST_ACK) begin
         st_nxt.code = `OPS_INT_ACK; // RULE_05
         st_nxt.neutralize_n_n = 1'b0; // RULE_06
      end else if (seq_op == `SEQ_RET_FIRST) begin
         st_nxt.code = `OPS_RET_FIRST; // RULE_07
      end else if (seq_op == `SEQ_RET_SECOND) begin
         st_nxt.code = `OPS_RET_SECOND; // RULE_08
         if (agen) begin
            // Restore word: assert form sits in the low 24 bits.
            st_nxt.ad = i_adr_reg; // RULE_09
            st_nxt.ad_drv = 1'b1;
         end
      end else if (xfer && i_instr[`XFER_EXT_BIT] &&
                   i_instr[`XFER_EXT_HI:`XFER_EXT_LO] <= `EXT_REG_MAX) begin
         st_nxt.code = {1'b1, i_instr[`XFER_EXT_HI:`XFER_EXT_LO]}; // RULE_13
      end else if (xfer && kind == `XFER_ST_IMG) begin
         st_nxt.code = pair_code(`OPS_ST_IMG, agen); // RULE_10
      end else if ((xfer && kind == `XFER_LD_IMG) || align) begin
         st_nxt.code = pair_code(`OPS_LD_IMG, agen); // RULE_11 RULE_15
      end else if (xfer && kind == `XFER_ST_COP) begin
         st_nxt.code = pair_code(`OPS_ST_COP, agen); // RULE_12
      end else if (xfer && kind == `XFER_LD_COP) begin
         st_nxt.code = pair_code(`OPS_LD_COP, agen); // RULE_12
      end else if (agen) begin
         st_nxt.code = `OPS_DATA_ADDR; // RULE_04
      end
      if (st_nxt.code == `OPS_DATA_ADDR ||
          (st_nxt.code[4:3] == 2'b01 && st_nxt.code[0])) begin
         st_nxt.ad = i_gen_addr;
         st_nxt.ad_drv = 1'b1;
      end
   end

   // ==========================================================
   // One register stage keeps the code stable all cycle.
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         st_r.phase <= ST_RUN;
         st_r.code <= `OPS_INT_ACK;
         st_r.neutralize_n_n <= 1'b1;
         st_r.ad <= 32'h00000000;
         st_r.ad_drv <= 1'b0;
         st_r.mie <= 1'b1;
         st_r.shadow_clr <= 1'b0;
         st_r.in_reset <= 1'b1;
      end else begin
         st_r <= st_nxt; // RULE_23
      end
   end

   assign link.operation_status_code = st_r.code;
   assign link.neutralize_n = st_r.neutralize_n_n;
   assign link.data_address_bus = st_r.ad;
   assign link.data_address_drive = st_r.ad_drv;
   assign link.master_int_enable = st_r.mie;
   assign o_shadow_clear = st_r.shadow_clr;
endmodule

// >>> opstat_monitor.sv
/*
 Checker for the operation status link.
 Assumes one clock; takes the link signals as plain inputs.
*/
`timescale 1ns/100ps
module opstat_monitor (
   // Clock, reset and link.
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [4:0] operation_status_code,
   input wire logic neutralize_n,
   input wire logic data_address_drive,
   input wire logic master_int_enable,
   input wire logic hold_request
);
   // ==========================================================
   // Sequences and properties, all on the system clock.
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   sequence s_ack;
      operation_status_code == 5'h02 && !master_int_enable;
   endsequence
   sequence s_ret_second;
      operation_status_code == 5'h07;
   endsequence
   property p_ack_neutralize_n; s_ack |-> !neutralize_n; endproperty
   property p_ack_mie; operation_status_code == 5'h02 && !neutralize_n |-> !master_int_enable;
   endproperty
   property p_mie_rise; $rose(master_int_enable) |-> s_ret_second; endproperty
   property p_ret_mie; s_ret_second |=> master_int_enable; endproperty
   property p_hold; hold_request |=> operation_status_code == 5'h00; endproperty
   property p_reserved; operation_status_code != 5'h1F; endproperty
   property p_agen; operation_status_code == 5'h01 |-> data_address_drive; endproperty
   property p_odd;
      operation_status_code inside {5'h09, 5'h0B, 5'h0D, 5'h0F} |-> data_address_drive;
   endproperty
   // The reset code must show while reset is high, so this one is never disabled.
   property p_reset;
      disable iff (1'b0) i_reset || $past(i_reset) |-> operation_status_code == 5'h02;
   endproperty
   a_ack_neutralize_n: assert property (p_ack_neutralize_n) else $error("ack not neutralized");
   a_ack_mie: assert property (p_ack_mie) else $error("enable high at ack");
   a_mie_rise: assert property (p_mie_rise) else $error("enable rose early");
   a_ret_mie: assert property (p_ret_mie) else $error("enable low after return");
   a_hold: assert property (p_hold) else $error("hold not honoured");
   a_reserved: assert property (p_reserved) else $error("reserved code");
   a_agen: assert property (p_agen) else $error("address not driven");
   a_odd: assert property (p_odd) else $error("odd code without address");
   a_reset: assert property (p_reset) else $error("reset code missing");
endmodule

// >>> tb_top.sv
/*
 Self-checking bench: both link ends joined, against a behavioural model.
 Assumes the design package and link interface are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
   import opstat_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b0;
   word_t i_instr = '0, i_adr_reg = '0, i_gen_addr = '0, o_data_address, xda;
   logic i_branch_shadow = 1'b0, i_int_take = 1'b0, i_hold = 1'b0;
   logic o_shadow_clear, o_load, o_store, o_ext_sel;
   logic [3:0] o_ext_num;
   int n_mismatch = 0, comparisons = 0, seed = 64783, pc = 2, ph = 0, k;
   // Ext word last: its number is filled in at random.
   word_t tbl [10] = '{32'h4000_0000, 32'h40A0_0000, 32'h40B0_0000, 32'h0020_0000,
      32'h0040_0000, 32'h00A0_0000, 32'h00C0_0000, 32'hF000_0000, 32'hF1A0_0000,
      32'h0000_8000};
   opstat_if link ();
   opstat_encoder opstat_encoder_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(link),
      .i_instr(i_instr), .i_branch_shadow(i_branch_shadow), .i_int_take(i_int_take),
      .i_adr_reg(i_adr_reg), .i_gen_addr(i_gen_addr), .o_shadow_clear(o_shadow_clear));
   opstat_decoder opstat_decoder_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(link),
      .i_hold(i_hold), .o_data_address(o_data_address), .o_load(o_load), .o_store(o_store),
      .o_ext_sel(o_ext_sel), .o_ext_num(o_ext_num));
   opstat_monitor opstat_monitor_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .operation_status_code(link.operation_status_code), .neutralize_n(link.neutralize_n),
      .data_address_drive(link.data_address_drive),
      .master_int_enable(link.master_int_enable), .hold_request(link.hold_request));
   // ==========================================================
   // Clock, compare and model.
   always #2 i_clk_sys = ~i_clk_sys;
   task automatic cmp_code(input opcode_t got, input opcode_t exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: code %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_out(input word_t got, input word_t exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: output %h expected %h", $time, got, exp);
      end
   endtask
   // Priority: hold, acknowledge, returns, address/align on non-transfer words, shadow, external, load/store.
   function automatic int model(word_t w, logic sh, logic tk, int hd);
      if (hd != 0) return 0;
      if (tk) return 2;
      if (w[31:24] == 8'hF0) return 4;
      if (w[31:24] == 8'hF1) return 7;
      if (w[31:24] != 8'h00) return (w[23:20] == 4'hA) ? 1 : (w[23:20] == 4'hB) ? 10 : 0;
      if (sh) return 0;
      if (w[15] && w[14:11] != 4'hF) return 16 + w[14:11];
      case (w[23:21])
         3'h1: return 8;
         3'h2: return 10;
         3'h5: return (w[23:20] == 4'hA) ? 13 : 12;
         3'h6: return 14;
         default: return 0;
      endcase
   endfunction
   // One cycle: drive at the falling edge, check just after the rising edge.
   task automatic step(input word_t w, input logic sh, input logic tk, input logic hd);
      int c;
      @(negedge i_clk_sys);
      i_instr = w;
      i_branch_shadow = sh;
      i_int_take = tk;
      i_hold = hd;
      i_gen_addr = $random(seed);
      i_adr_reg = $random(seed);
      c = model(w, sh, tk, ph);
      ph = hd;
      @(posedge i_clk_sys);
      #1;
      cmp_code(link.operation_status_code, c[4:0]);
      cmp_out(o_shadow_clear, sh);
      cmp_out(o_load, pc inside {10, 11, 14, 15});
      cmp_out(o_store, pc inside {8, 9, 12, 13});
      cmp_out(o_ext_sel, pc >= 16);
      if (pc >= 16) cmp_out(o_ext_num, pc - 16);
      cmp_out(o_data_address, xda);
      if (c == 1) cmp_out(link.data_address_bus, i_gen_addr);
      if (c == 7) cmp_out(link.data_address_bus, i_adr_reg);
      if (c inside {1, 7, 13}) xda = (c == 7) ? i_adr_reg : i_gen_addr;
      pc = c;
   endtask
   task automatic rst();
      @(negedge i_clk_sys);
      i_reset = 1'b1;
      i_hold = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      #1;
      cmp_code(link.operation_status_code, 5'h02);
      @(negedge i_clk_sys);
      i_reset = 1'b0;
      @(posedge i_clk_sys);
      #1;
      cmp_code(link.operation_status_code, 5'h02);
      pc = 2;
      ph = 0;
      xda = '0;
   endtask
   task automatic rnd(input int n);
      word_t w;
      repeat (n) begin
         w = tbl[{$random(seed)} % 10];
         w[14:11] = {$random(seed)} % 16;
         step(w, (w[31:24] == 8'h00 && w[23:20] != 4'hA) ? $random(seed) : 1'b0, 1'b0,
            ({$random(seed)} % 4) == 0);
      end
   endtask
   task automatic finish_test();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence and watchdog.
   initial begin
      // Raise reset before the first clock edge so no unknown code is ever sampled.
      #1;
      i_reset = 1'b1;
      rst();
      for (k = 0; k < 3; k++) begin
         step(tbl[k], 1'b0, 1'b1, 1'b0);
         cmp_out(link.neutralize_n, 1'b0);
         cmp_out(link.master_int_enable, 1'b0);
         repeat (3) step(tbl[{$random(seed)} % 7], 1'b0, 1'b0, 1'b0);
         // This table index is in unsigned braces, so $random cannot make it negative.
         cmp_out(link.master_int_enable, 1'b0);
         step(tbl[7], 1'b0, 1'b0, 1'b0);
         step(tbl[8], 1'b0, 1'b0, 1'b0);
         step(tbl[0], 1'b0, 1'b0, 1'b0);
         cmp_out(link.master_int_enable, 1'b1);
      end
      $display("test interrupt done");
      rnd(200);
      $display("test random done");
      rst();
      rnd(50);
      $display("test second reset done");
      finish_test();
   end
   initial begin
      #8000;
      n_mismatch++;
      finish_test();
   end
endmodule
